// >>> hw/licr_regs.svh
// Register offsets, field positions, reset values and timing for line control.
`ifndef LICR_REGS_SVH
`define LICR_REGS_SVH
`define LICR_OFS_LINE_CTRL 8'h05
`define LICR_OFS_POWER_CTRL 8'h06
`define LICR_OFS_RATE_SEL 8'h07
`define LICR_OFS_SPARE_A 8'h08
`define LICR_OFS_SPARE_B 8'h09
`define LICR_OFS_LOOPBACK 8'h0a
`define LICR_BIT_RING_NEG 6
`define LICR_BIT_RING_POS 5
`define LICR_BIT_MONITOR 3
`define LICR_BIT_RING_PROG 2
`define LICR_BIT_OFFHOOK 0
`define LICR_BIT_LINE_PD 4
`define LICR_BIT_SYS_PD 3
`define LICR_BIT_DOUBLE 3
`define LICR_BIT_LOOPBACK 0
`define LICR_RST_LINE_CTRL 8'h00
`define LICR_RST_POWER_CTRL 8'h10
`define LICR_RST_RATE_SEL 8'h00
`define LICR_RST_LOOPBACK 8'h00
`define LICR_ZERO_BYTE 8'h00
`define LICR_RING_HOLD_MS 5000
`define LICR_CLK_KHZ 20000
`define LICR_RING_HOLD_CYCLES (`LICR_RING_HOLD_MS * `LICR_CLK_KHZ)
`define LICR_TIMER_W 27
`define LICR_SLOT_W 5
`endif

// >>> hw/licr_pkg.sv
// Types shared by the line interface control register block.
package licr_pkg;
    typedef struct packed {
        logic offhook_command;
        logic onhook_monitor_enable;
        logic line_side_powerdown;
        logic system_side_powerdown;
        logic double_rate_sampling;
        logic digital_loopback_enable;
    } licr_ctrl_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } licr_req_t;
endpackage : licr_pkg

// >>> hw/licr_top.sv
// Line interface control registers: hook, ring status, power, rate, loopback.
//
// Contract
// - line control bit 6 shows negative ring
// - line control bit 5 shows positive ring
// - line control bit 3 selects on-hook monitoring
// - ring flag clears 5 s later or off-hook
// - full-wave option lets negative rings set flag
// - line control bit 0 commands off-hook
// - power bit 4 powers down line side
// - power bit 3 halts system side until reset
// - rate bit 3 selects 8 or 16 kHz
// - 16 kHz uses two adjacent timeslots per frame
// - loopback bit 0 returns receive data to transmit
`timescale 1ns/10ps
`include "licr_regs.svh"

module licr_top #(
    parameter logic [`LICR_TIMER_W-1:0] RING_HOLD_CYCLES =
        `LICR_TIMER_W'(`LICR_RING_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Control port
    input wire licr_pkg::licr_req_t REQ,
    output logic [7:0] RDATA,
    // Line-side ring detector and options
    input wire logic RING_POS,
    input wire logic RING_NEG,
    input wire logic FULL_WAVE_RING_OPTION,
    // Line-side commands
    output licr_pkg::licr_ctrl_t CTRL,
    output logic RING_IN_PROGRESS,
    // Voice highway
    input wire logic FRAME_SYNC,
    input wire logic SLOT_STROBE,
    input wire logic [`LICR_SLOT_W-1:0] ASSIGNED_SLOT,
    input wire logic SERIAL_RECEIVE_INPUT,
    input wire logic TX_PATH_DATA,
    output logic SERIAL_TRANSMIT_OUTPUT,
    output logic SAMPLE_SLOT_EN
);

    ////////////////////////////////////////////////////////////////////////
    licr_pkg::licr_ctrl_t ctrl_r;
    logic ring_pos_r;
    logic ring_neg_r;
    logic ring_prog_r;
    logic [`LICR_TIMER_W-1:0] hold_cnt_r;
    logic [`LICR_SLOT_W-1:0] slot_cnt_r;
    logic [7:0] rdata_nxt;
    logic wr_ok;
    logic offhook_wr;
    logic qual_ring;
    // Power control reset byte, so its field can be picked out by position.
    localparam logic [7:0] pwr_rst = `LICR_RST_POWER_CTRL;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // A powered-down system side takes no more writes until reset.
    assign wr_ok = REQ.wr && !ctrl_r.system_side_powerdown;
    assign offhook_wr = wr_ok && hit(REQ.addr, `LICR_OFS_LINE_CTRL) &&
        REQ.wdata[`LICR_BIT_OFFHOOK];
    assign qual_ring = (RING_POS && !ring_pos_r) ||
        (FULL_WAVE_RING_OPTION && RING_NEG && !ring_neg_r);

    ////////////////////////////////////////////////////////////////////////
    // Writable control fields; read-only and reserved bits are dropped.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl_r <= '0;
            ctrl_r.line_side_powerdown <= pwr_rst[`LICR_BIT_LINE_PD];
        end
        else if (wr_ok)
        begin
            if (hit(REQ.addr, `LICR_OFS_LINE_CTRL))
            begin
                ctrl_r.offhook_command <= REQ.wdata[`LICR_BIT_OFFHOOK];
                ctrl_r.onhook_monitor_enable <=
                    REQ.wdata[`LICR_BIT_MONITOR];
            end
            if (hit(REQ.addr, `LICR_OFS_POWER_CTRL))
            begin
                ctrl_r.line_side_powerdown <=
                    REQ.wdata[`LICR_BIT_LINE_PD];
                ctrl_r.system_side_powerdown <=
                    REQ.wdata[`LICR_BIT_SYS_PD];
            end
            if (hit(REQ.addr, `LICR_OFS_RATE_SEL))
                ctrl_r.double_rate_sampling <=
                    REQ.wdata[`LICR_BIT_DOUBLE];
            if (hit(REQ.addr, `LICR_OFS_LOOPBACK))
                ctrl_r.digital_loopback_enable <=
                    REQ.wdata[`LICR_BIT_LOOPBACK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring status sampling and ring-in-progress hold timer.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ring_pos_r <= 1'b0;
            ring_neg_r <= 1'b0;
        end
        else
        begin
            ring_pos_r <= RING_POS;
            ring_neg_r <= RING_NEG;
        end
    end

    // A new ring wins over the off-hook clear in the same cycle.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ring_prog_r <= 1'b0;
            hold_cnt_r <= '0;
        end
        else if (qual_ring)
        begin
            ring_prog_r <= 1'b1;
            hold_cnt_r <= RING_HOLD_CYCLES;
        end
        else if (offhook_wr)
        begin
            ring_prog_r <= 1'b0;
            hold_cnt_r <= '0;
        end
        else if (hold_cnt_r != '0)
        begin
            hold_cnt_r <= hold_cnt_r - `LICR_TIMER_W'(1);
            ring_prog_r <= (hold_cnt_r != `LICR_TIMER_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read path, answered one cycle after the read strobe.
    always_comb
    begin
        rdata_nxt = `LICR_ZERO_BYTE;
        if (hit(REQ.addr, `LICR_OFS_LINE_CTRL))
        begin
            rdata_nxt[`LICR_BIT_RING_NEG] = ring_neg_r;
            rdata_nxt[`LICR_BIT_RING_POS] = ring_pos_r;
            rdata_nxt[`LICR_BIT_MONITOR] = ctrl_r.onhook_monitor_enable;
            rdata_nxt[`LICR_BIT_RING_PROG] = ring_prog_r;
            rdata_nxt[`LICR_BIT_OFFHOOK] = ctrl_r.offhook_command;
        end
        if (hit(REQ.addr, `LICR_OFS_POWER_CTRL))
        begin
            rdata_nxt[`LICR_BIT_LINE_PD] = ctrl_r.line_side_powerdown;
            rdata_nxt[`LICR_BIT_SYS_PD] = ctrl_r.system_side_powerdown;
        end
        if (hit(REQ.addr, `LICR_OFS_RATE_SEL))
            rdata_nxt[`LICR_BIT_DOUBLE] = ctrl_r.double_rate_sampling;
        if (hit(REQ.addr, `LICR_OFS_LOOPBACK))
            rdata_nxt[`LICR_BIT_LOOPBACK] = ctrl_r.digital_loopback_enable;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            RDATA <= `LICR_ZERO_BYTE;
        else if (REQ.rd)
            RDATA <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops for line-side commands and ring flag.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            CTRL <= '0;
            CTRL.line_side_powerdown <= pwr_rst[`LICR_BIT_LINE_PD];
            RING_IN_PROGRESS <= 1'b0;
        end
        else
        begin
            CTRL <= ctrl_r;
            RING_IN_PROGRESS <= ring_prog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timeslot tracking; double rate claims the assigned slot and the next.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            slot_cnt_r <= '0;
        else if (FRAME_SYNC)
            slot_cnt_r <= '0;
        else if (SLOT_STROBE)
            slot_cnt_r <= slot_cnt_r + `LICR_SLOT_W'(1);
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            SAMPLE_SLOT_EN <= 1'b0;
        else
            SAMPLE_SLOT_EN <= (slot_cnt_r == ASSIGNED_SLOT) ||
                (ctrl_r.double_rate_sampling &&
                 slot_cnt_r == ASSIGNED_SLOT + `LICR_SLOT_W'(1));
    end

    // Loopback is taken ahead of the filters, so the bit is returned as is.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            SERIAL_TRANSMIT_OUTPUT <= 1'b0;
        else
            SERIAL_TRANSMIT_OUTPUT <= ctrl_r.digital_loopback_enable ?
                SERIAL_RECEIVE_INPUT : TX_PATH_DATA;
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RING_NEG_READ: assert property (@(posedge CLK) disable iff (RESET)
        REQ.rd && hit(REQ.addr, `LICR_OFS_LINE_CTRL) ##1 1 |->
        RDATA[`LICR_BIT_RING_NEG] == $past(RING_NEG, 2))
        else $error("negative ring status wrong");
    AST_RING_POS_READ: assert property (@(posedge CLK) disable iff (RESET)
        REQ.rd && hit(REQ.addr, `LICR_OFS_LINE_CTRL) ##1 1 |->
        RDATA[`LICR_BIT_RING_POS] == $past(RING_POS, 2))
        else $error("positive ring status wrong");
    AST_MONITOR_OUT: assert property (@(posedge CLK) disable iff (RESET)
        wr_ok && hit(REQ.addr, `LICR_OFS_LINE_CTRL) |-> ##2
        CTRL.onhook_monitor_enable == $past(REQ.wdata[`LICR_BIT_MONITOR], 2))
        else $error("monitor mode not applied");
    AST_OFFHOOK_CLEARS: assert property (@(posedge CLK) disable iff (RESET)
        offhook_wr && !qual_ring |=> !ring_prog_r)
        else $error("off-hook did not clear ring flag");
    AST_HALF_WAVE: assert property (@(posedge CLK) disable iff (RESET)
        !ring_prog_r && !FULL_WAVE_RING_OPTION && !(RING_POS && !ring_pos_r)
        |=> !ring_prog_r)
        else $error("ring flag set without positive ring");
    AST_RING_SETS: assert property (@(posedge CLK) disable iff (RESET)
        qual_ring |=> ring_prog_r ##1 RING_IN_PROGRESS)
        else $error("qualifying ring did not set flag");
    AST_SYS_PD_STICKS: assert property (@(posedge CLK) disable iff (RESET)
        ctrl_r.system_side_powerdown |=> ctrl_r.system_side_powerdown &&
        $stable(ctrl_r))
        else $error("system side left power-down without reset");
    AST_LINE_PD_OUT: assert property (@(posedge CLK) disable iff (RESET)
        wr_ok && hit(REQ.addr, `LICR_OFS_POWER_CTRL) |-> ##2
        CTRL.line_side_powerdown == $past(REQ.wdata[`LICR_BIT_LINE_PD], 2))
        else $error("line power-down not applied");
    AST_LOOPBACK: assert property (@(posedge CLK) disable iff (RESET)
        ctrl_r.digital_loopback_enable |=>
        SERIAL_TRANSMIT_OUTPUT == $past(SERIAL_RECEIVE_INPUT))
        else $error("loopback data differs");
    AST_RESERVED_ZERO: assert property (@(posedge CLK) disable iff (RESET)
        REQ.rd && (hit(REQ.addr, `LICR_OFS_SPARE_A) ||
        hit(REQ.addr, `LICR_OFS_SPARE_B)) |=> RDATA == `LICR_ZERO_BYTE)
        else $error("reserved register not zero");

endmodule : licr_top

// >>> verification/licr_host_model.sv
// Host controller model that drives the register control port.
`timescale 1ns/10ps
module licr_host_model (
    // Clock
    input wire logic clk,
    // Control port
    output licr_pkg::licr_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;

    ////////////////////////////////////////
    // Strobes last one cycle. Idle address is inverted, and idle data after a write,
    // so that stale values are never mistaken for a request.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
        req.addr = ~a;
        req.wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        req.addr = ~a;
        @(negedge clk);
        v = rdata;
    endtask : rd

    // The clock generator is set up before this is called; power control is
    // cleared first, then 8'h00 goes to offset 04, which holds no register.
    task automatic line_up;
        wr(8'h06, 8'h00);
        wr(8'h04, 8'h00);
    endtask : line_up
endmodule : licr_host_model

// >>> verification/licr_top_tb_top.sv
// Self-checking testbench for the line interface control registers.
`timescale 1ns/10ps
module licr_top_tb_top;
    localparam int HOLD = 20;
    logic clk = 1'b0;
    logic reset = 1'b1;
    licr_pkg::licr_req_t req;
    logic [7:0] rdata;
    logic ring_pos = 1'b0;
    logic ring_neg = 1'b0;
    logic full_wave = 1'b0;
    licr_pkg::licr_ctrl_t ctrl;
    logic ring_prog;
    logic frame_sync = 1'b0;
    logic slot_strobe = 1'b0;
    logic [4:0] slot_sel = 5'h03;
    logic rx_bit = 1'b0;
    logic tx_bit = 1'b0;
    logic tx_out;
    logic slot_en;
    logic [7:0] v;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    licr_host_model host (.clk(clk), .req(req), .rdata(rdata));

    licr_top #(.RING_HOLD_CYCLES(HOLD)) dut (
        .CLK(clk), .RESET(reset), .REQ(req), .RDATA(rdata),
        .RING_POS(ring_pos), .RING_NEG(ring_neg),
        .FULL_WAVE_RING_OPTION(full_wave), .CTRL(ctrl),
        .RING_IN_PROGRESS(ring_prog), .FRAME_SYNC(frame_sync),
        .SLOT_STROBE(slot_strobe), .ASSIGNED_SLOT(slot_sel),
        .SERIAL_RECEIVE_INPUT(rx_bit), .TX_PATH_DATA(tx_bit),
        .SERIAL_TRANSMIT_OUTPUT(tx_out), .SAMPLE_SLOT_EN(slot_en)
    );

    ////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk($sformatf("register %h", a), e, v);
    endtask : rchk

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cyc

    task automatic slot_chk(input int n, input logic e);
        @(negedge clk) frame_sync = 1'b1;
        @(negedge clk) frame_sync = 1'b0;
        repeat (n)
        begin
            @(negedge clk) slot_strobe = 1'b1;
            @(negedge clk) slot_strobe = 1'b0;
        end
        wait_cyc(2);
        chk("slot enable", {7'h00, e}, {7'h00, slot_en});
    endtask : slot_chk

    task automatic lb_chk(input logic lb);
        for (int i = 0; i < 4; i++)
        begin
            rx_bit = i[0];
            tx_bit = i[1];
            @(negedge clk);
            chk("serial out", {7'h00, lb ? i[0] : i[1]}, {7'h00, tx_out});
        end
    endtask : lb_chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            stop_test();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        wait_cyc(5);
        reset = 1'b0;
        rchk(8'h05, 8'h00);
        rchk(8'h06, 8'h10);
        rchk(8'h07, 8'h00);
        rchk(8'h09, 8'h00);
        rchk(8'h0a, 8'h00);
        rchk(8'h0b, 8'h00);
        host.wr(8'h08, 8'hff);
        rchk(8'h08, 8'h00);
        chk("ctrl", 8'h08, {2'b00, ctrl});
        host.wr(8'h05, 8'hff);
        rchk(8'h05, 8'h09);
        chk("ctrl", 8'h38, {2'b00, ctrl});
        $display("test reset and hook done");
        host.wr(8'h05, 8'h00);
        ring_pos = 1'b1;
        rchk(8'h05, 8'h24);
        chk("ring out", 8'h01, {7'h00, ring_prog});
        ring_pos = 1'b0;
        wait_cyc(12);
        rchk(8'h05, 8'h04);
        wait_cyc(6);
        rchk(8'h05, 8'h00);
        ring_neg = 1'b1;
        rchk(8'h05, 8'h40);
        ring_neg = 1'b0;
        @(negedge clk);
        full_wave = 1'b1;
        ring_neg = 1'b1;
        rchk(8'h05, 8'h44);
        host.wr(8'h05, 8'h01);
        rchk(8'h05, 8'h41);
        chk("ring out", 8'h00, {7'h00, ring_prog});
        ring_neg = 1'b0;
        $display("test ring done");
        slot_chk(3, 1'b1);
        slot_chk(4, 1'b0);
        host.wr(8'h07, 8'hff);
        rchk(8'h07, 8'h08);
        chk("ctrl", 8'h2a, {2'b00, ctrl});
        slot_chk(4, 1'b1);
        slot_chk(5, 1'b0);
        slot_chk(2, 1'b0);
        slot_sel = 5'h0a;
        slot_chk(10, 1'b1);
        slot_chk(11, 1'b1);
        slot_chk(3, 1'b0);
        lb_chk(1'b0);
        host.wr(8'h0a, 8'hff);
        rchk(8'h0a, 8'h01);
        lb_chk(1'b1);
        host.wr(8'h0a, 8'h00);
        $display("test rate and loopback done");
        host.line_up();
        rchk(8'h06, 8'h00);
        chk("ctrl", 8'h22, {2'b00, ctrl});
        host.wr(8'h06, 8'he8);
        rchk(8'h06, 8'h08);
        host.wr(8'h05, 8'h00);
        rchk(8'h05, 8'h01);
        chk("ctrl", 8'h26, {2'b00, ctrl});
        reset = 1'b1;
        wait_cyc(2);
        reset = 1'b0;
        rchk(8'h06, 8'h10);
        rchk(8'h07, 8'h00);
        $display("test power done");
        stop_test();
    end
endmodule : licr_top_tb_top
